// File: hdl/abl_cfg.svh
`ifndef ABL_CFG_SVH
`define ABL_CFG_SVH
// ****************************************
// timing
// ****************************************
`define ABL_CLK_NS        4
`define ABL_FILT_NS       1000
`define ABL_FILT_CYC      ((`ABL_FILT_NS + `ABL_CLK_NS - 1) / `ABL_CLK_NS)
`define ABL_CLR_MIN_NS    2000
`define ABL_CLR_MIN_CYC   ((`ABL_CLR_MIN_NS + `ABL_CLK_NS - 1) / `ABL_CLK_NS)
`define ABL_CLR_MAX_NS    20000
`define ABL_CLR_MAX_CYC   (`ABL_CLR_MAX_NS / `ABL_CLK_NS)
`define ABL_REC_MS        100
`define ABL_REC_CYC       (`ABL_REC_MS * 1000000 / `ABL_CLK_NS)
`define ABL_GATE_STEP_CYC 16
// ****************************************
// levels
// ****************************************
`define ABL_GATE_MAX_UA   8'he6
`define ABL_CODE_MAX      8'hff
`define ABL_CODE_MIN      8'h00
`define ABL_CODE_INIT     8'he1
// ****************************************
// register map
// ****************************************
`define ABL_CTRL_ADDR     8'h00
`define ABL_STAT_ADDR     8'h04
`define ABL_CTRL_RST      32'h0004_00fa
`define ABL_CTRL_DP_LSB   16
`define ABL_STAT_OPEN_LSB 4
`define ABL_STAT_SHRT_LSB 8
`define ABL_STAT_DET_LSB  12
`define ABL_STAT_CODE_LSB 16
`define ABL_STAT_CUT_BIT  24
`define ABL_STAT_DER_BIT  25
`endif

// File: hdl/abl_pkg.sv
package abl_pkg;
  // ****************************************
  // device states
  // ****************************************
  typedef enum logic [1:0] {
    ABL_STANDBY  = 2'b00,
    ABL_START    = 2'b01,
    ABL_ACTIVE   = 2'b10,
    ABL_RECOVERY = 2'b11
  } abl_state_t;
endpackage

// File: hdl/abl_top.sv
`timescale 1ns/1ps
// Contract
// - grounded sinks detected at start, then excluded
// - sink PWM follows input PWM directly
// - enable ramps FET gate current to 230
// - shutdown turns power FET off
// - recovery state turns power FET off
// - thermistor onset starts current de-rating
// - de-rated to 17.5 percent cuts current off
// - grounded setpoint disables thermal de-rating
// - target follows highest forward voltage string
// - target moves in steps of span/256
// - periodic downward pressure on target
// - three comparators per sink, 1 us filtered
// - all inside window holds target, except on periodic downward-pressure ticks
// - all above high headroom steps down
// - any below low headroom steps up
// - maximum target and low sink flags open
// - short level with other in window flags short
// - recovery: outputs off, fault low, 100 ms retry
// - LED fault disables only faulty string
// - short enable low pulse clears LED faults
// - long enable low enters standby
`include "abl_cfg.svh"
module abl_top import abl_pkg::*; #(
  parameter int NSINK       = 4,
  parameter int REC_CYC     = `ABL_REC_CYC,
  parameter int CLR_MAX_CYC = `ABL_CLR_MAX_CYC
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  input  wire logic             io_supply_enable_pin,
  input  wire logic             pwm_in,
  input  wire logic             input_overvoltage_fault,
  input  wire logic             input_undervoltage_lockout,
  input  wire logic             input_overcurrent_fault,
  input  wire logic             die_overtemperature_shutdown,
  input  wire logic             thermal_setpoint_grounded,
  input  wire logic             thermistor_onset,
  input  wire logic             thermistor_cutoff,
  input  wire logic [NSINK-1:0] sink_below_low,
  input  wire logic [NSINK-1:0] sink_above_mid,
  input  wire logic [NSINK-1:0] sink_above_short,
  input  wire logic [NSINK-1:0] sink_grounded,
  output logic      [NSINK-1:0] sink_pwm,
  output logic      [7:0]       boost_target,
  output logic                  boost_enable,
  output logic      [7:0]       power_fet_gate_drive,
  output logic                  fault_n,
  output logic                  derate_active,
  output logic                  led_current_cut
);
  localparam int NCMP = 3 * NSINK;
  localparam int NIN  = 9 + 4 * NSINK;
  localparam int RW   = $clog2(REC_CYC + 1);
  localparam int LW   = $clog2(CLR_MAX_CYC + 1);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1;
  logic [NIN-1:0] sync2;
  logic [NIN-1:0] sync3;
  logic [NIN-1:0] clean;
  logic [NIN-1:0] next_clean;

  assign raw_in = {sink_grounded, sink_above_short, sink_above_mid, sink_below_low,
                   thermistor_cutoff, thermistor_onset, thermal_setpoint_grounded,
                   die_overtemperature_shutdown, input_overcurrent_fault,
                   input_undervoltage_lockout, input_overvoltage_fault, pwm_in,
                   io_supply_enable_pin};

  // a bit only moves when stages two and three agree
  always_comb begin
    next_clean = (sync2 & sync3) | (clean & (sync2 ^ sync3));
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      clean <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
      clean <= next_clean;
    end
  end

  logic en;
  logic pwm;
  logic sys_fault;
  logic thermal_setpoint_pin_gnd;
  logic onset;
  logic cutoff;
  logic [NSINK-1:0] strap;
  logic [NCMP-1:0]  cmp_in;

  assign en        = clean[0];
  assign pwm       = clean[1];
  assign sys_fault = |clean[5:2];
  assign thermal_setpoint_pin_gnd  = clean[6];
  assign onset     = clean[7];
  assign cutoff    = clean[8];
  assign cmp_in    = clean[9 +: NCMP];
  assign strap     = clean[9 + NCMP +: NSINK];

  // ****************************************
  // comparator filters
  // ****************************************
  logic [NCMP-1:0] cmp_filt;

  // a level must hold for the full filter time before it is taken
  for (genvar g = 0; g < NCMP; g++) begin : g_filt
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       next_f;
    always_comb begin
      next_cnt = '0;
      next_f   = cmp_filt[g];
      if (cmp_in[g] != cmp_filt[g]) begin
        if (cnt == 8'(`ABL_FILT_CYC - 1)) begin
          next_f = cmp_in[g];
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
    end
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        cnt         <= '0;
        cmp_filt[g] <= 1'b0;
      end else begin
        cnt         <= next_cnt;
        cmp_filt[g] <= next_f;
      end
    end
  end

  logic [NSINK-1:0] below_low;
  logic [NSINK-1:0] above_mid;
  logic [NSINK-1:0] above_short;
  assign below_low   = cmp_filt[0 +: NSINK];
  assign above_mid   = cmp_filt[NSINK +: NSINK];
  assign above_short = cmp_filt[2*NSINK +: NSINK];

  // ****************************************
  // control register
  // ****************************************
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [15:0] adapt_div;
  logic [3:0]  dp_div;
  assign adapt_div = ctrl[15:0];
  assign dp_div    = ctrl[`ABL_CTRL_DP_LSB +: 4];

  always_comb begin
    next_ctrl = ctrl;
    if (reg_wr && reg_addr == `ABL_CTRL_ADDR) begin
      next_ctrl = {12'h000, reg_wdata[19:0]};
    end
  end

  // ****************************************
  // sequencing and adaptation
  // ****************************************
  abl_state_t       state;
  abl_state_t       next_state;
  logic [NSINK-1:0] det;
  logic [NSINK-1:0] next_det;
  logic [NSINK-1:0] open_f;
  logic [NSINK-1:0] next_open;
  logic [NSINK-1:0] short_f;
  logic [NSINK-1:0] next_short;
  logic [7:0]       next_code;
  logic [7:0]       next_gate;
  logic [15:0]      tick_cnt;
  logic [15:0]      next_tick;
  logic [3:0]       dp_cnt;
  logic [3:0]       next_dp;
  logic [3:0]       gstep;
  logic [3:0]       next_gstep;
  logic [RW-1:0]    rec_cnt;
  logic [RW-1:0]    next_rec;
  logic [LW-1:0]    low_cnt;
  logic [LW-1:0]    next_low;
  logic             therm_cut;
  logic             next_cut;
  logic [NSINK-1:0] act;
  logic [NSINK-1:0] window;
  logic [NSINK-1:0] short_new;
  logic             any_low;
  logic             all_mid;
  logic             adapt_tick;
  logic             dp_tick;
  logic             derate;

  assign act        = det & ~open_f & ~short_f;
  assign window     = act & ~below_low & ~above_mid;
  assign any_low    = |(below_low & act);
  assign all_mid    = (act != '0) && ((above_mid & act) == act);
  assign adapt_tick = (tick_cnt >= adapt_div);
  assign dp_tick    = adapt_tick && (dp_cnt >= dp_div);
  assign derate     = onset && !thermal_setpoint_pin_gnd;

  // a string over the short level while another sits in the window
  always_comb begin
    for (int i = 0; i < NSINK; i++) begin
      short_new[i] = act[i] && above_short[i] && ((window & ~(NSINK'(1) << i)) != '0);
    end
  end

  always_comb begin
    next_state = state;
    next_det   = det;
    next_open  = open_f;
    next_short = short_f;
    next_code  = boost_target;
    next_tick  = adapt_tick ? 16'h0000 : tick_cnt + 16'h0001;
    next_dp    = dp_cnt;
    next_rec   = '0;
    next_low   = '0;
    next_gate  = power_fet_gate_drive;
    next_gstep = gstep + 4'h1;
    // soft gate ramp limits inrush while enabled
    if (gstep == 4'(`ABL_GATE_STEP_CYC - 1) && power_fet_gate_drive != `ABL_GATE_MAX_UA) begin
      next_gate = power_fet_gate_drive + 8'h01;
    end
    // cut latches until the temperature is back in range; clear wins
    next_cut = (therm_cut && derate) || (derate && cutoff);
    unique case (state)
      ABL_STANDBY: begin
        next_gate  = '0;
        next_code  = `ABL_CODE_INIT;
        next_open  = '0;
        next_short = '0;
        if (en) begin
          next_det   = ~strap;
          next_state = ABL_START;
        end
      end
      ABL_START: begin
        if (!en) begin
          next_state = ABL_STANDBY;
        end else if (sys_fault) begin
          next_state = ABL_RECOVERY;
        end else if (power_fet_gate_drive == `ABL_GATE_MAX_UA) begin
          next_state = ABL_ACTIVE;
        end
      end
      ABL_ACTIVE: begin
        if (sys_fault) begin
          next_state = ABL_RECOVERY;
        end else if (!en) begin
          // low pulse: leds dark, long one means standby
          next_low = (low_cnt == LW'(CLR_MAX_CYC)) ? low_cnt : low_cnt + LW'(1);
          if (low_cnt >= LW'(CLR_MAX_CYC - 1)) begin
            next_state = ABL_STANDBY;
          end
        end else begin
          if (low_cnt >= LW'(`ABL_CLR_MIN_CYC)) begin
            next_open  = '0;
            next_short = '0;
          end
          if (adapt_tick) begin
            next_dp = dp_tick ? 4'h0 : dp_cnt + 4'h1;
            if (any_low) begin
              if (boost_target != `ABL_CODE_MAX) begin
                next_code = boost_target + 8'h01;
              end else begin
                next_open = next_open | (below_low & act);
              end
            end else if (all_mid || dp_tick) begin
              if (boost_target != `ABL_CODE_MIN) begin
                next_code = boost_target - 8'h01;
              end
            end
          end
          next_short = next_short | short_new;
        end
      end
      ABL_RECOVERY: begin
        next_gate = '0;
        next_rec  = (rec_cnt == RW'(REC_CYC - 1)) ? rec_cnt : rec_cnt + RW'(1);
        if (rec_cnt == RW'(REC_CYC - 1) && !sys_fault) begin
          next_state = ABL_START;
          next_rec   = '0;
        end
      end
    endcase
  end

  // outputs are registered from the present state
  logic             led_on;
  logic [NSINK-1:0] next_pwm;
  assign led_on   = (state == ABL_ACTIVE) && en && !therm_cut;
  assign next_pwm = {NSINK{pwm && led_on}} & act;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state                <= ABL_STANDBY;
      ctrl                 <= `ABL_CTRL_RST;
      det                  <= '0;
      open_f               <= '0;
      short_f              <= '0;
      boost_target         <= `ABL_CODE_INIT;
      power_fet_gate_drive <= '0;
      tick_cnt             <= '0;
      dp_cnt               <= '0;
      gstep                <= '0;
      rec_cnt              <= '0;
      low_cnt              <= '0;
      therm_cut            <= 1'b0;
      sink_pwm             <= '0;
      boost_enable         <= 1'b0;
      fault_n              <= 1'b1;
      derate_active        <= 1'b0;
      led_current_cut      <= 1'b0;
    end else begin
      state                <= next_state;
      ctrl                 <= next_ctrl;
      det                  <= next_det;
      open_f               <= next_open;
      short_f              <= next_short;
      boost_target         <= next_code;
      power_fet_gate_drive <= next_gate;
      tick_cnt             <= next_tick;
      dp_cnt               <= next_dp;
      gstep                <= next_gstep;
      rec_cnt              <= next_rec;
      low_cnt              <= next_low;
      therm_cut            <= next_cut;
      sink_pwm             <= next_pwm;
      boost_enable         <= (state == ABL_START) || (state == ABL_ACTIVE);
      fault_n              <= !((state == ABL_RECOVERY) || (|open_f) || (|short_f));
      derate_active        <= derate;
      led_current_cut      <= therm_cut;
    end
  end

  // ****************************************
  // register read
  // ****************************************
  logic [31:0] stat;
  always_comb begin
    stat = '0;
    stat[1:0] = state;
    stat[`ABL_STAT_OPEN_LSB +: NSINK] = open_f;
    stat[`ABL_STAT_SHRT_LSB +: NSINK] = short_f;
    stat[`ABL_STAT_DET_LSB +: NSINK]  = det;
    stat[`ABL_STAT_CODE_LSB +: 8]     = boost_target;
    stat[`ABL_STAT_CUT_BIT]           = therm_cut;
    stat[`ABL_STAT_DER_BIT]           = derate;
  end

  // unmapped addresses and idle cycles read as zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd && reg_addr == `ABL_CTRL_ADDR) begin
      reg_rdata <= ctrl;
    end else if (reg_rd && reg_addr == `ABL_STAT_ADDR) begin
      reg_rdata <= stat;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence up_cause;
    state == ABL_ACTIVE && en && !sys_fault && adapt_tick && any_low;
  endsequence
  sequence down_cause;
    state == ABL_ACTIVE && en && !sys_fault && adapt_tick && !any_low && all_mid;
  endsequence

  gate_off_recovery_a: assert property (state == ABL_RECOVERY |=> power_fet_gate_drive == '0)
    else $error("gate drive on during recovery");
  gate_off_standby_a: assert property (state == ABL_STANDBY |=> power_fet_gate_drive == '0)
    else $error("gate drive on in standby");
  grounded_sink_a: assert property ((sink_pwm & ~det) == '0)
    else $error("grounded sink driven");
  pwm_track_a: assert property (sink_pwm != '0 |-> $past(pwm) && !$past(therm_cut))
    else $error("sink pwm without input pwm");
  step_up_a: assert property (up_cause and boost_target != `ABL_CODE_MAX
                              |=> boost_target == $past(boost_target) + 8'h01)
    else $error("target did not step up");
  step_down_a: assert property (down_cause and boost_target != `ABL_CODE_MIN
                                |=> boost_target == $past(boost_target) - 8'h01)
    else $error("target did not step down");
  // no tick, or no cause to move: the code must stay put
  target_hold_a: assert property (state == ABL_ACTIVE
                                  && (!adapt_tick || (!any_low && !all_mid && !dp_tick))
                                  |=> $stable(boost_target))
    else $error("target moved without cause");
  open_flag_a: assert property (up_cause and boost_target == `ABL_CODE_MAX |=> open_f != '0)
    else $error("open string not flagged");
  fault_pin_a: assert property (state == ABL_RECOVERY |=> !fault_n)
    else $error("fault pin released in recovery");
endmodule

// File: verif/abl_host_model.sv
`timescale 1ns/1ps
// ****************************************
// host side: enable pin and brightness pwm
// ****************************************
module abl_host_model #(
  parameter int PWM_PER = 12500,
  parameter int CLR_LOW = 550
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        en_cmd,
  input  wire logic        clr_req,
  input  wire logic [15:0] duty,
  output logic             io_supply_enable_pin,
  output logic             pwm_in
);
  logic [15:0] pcnt, next_pcnt, lcnt, next_lcnt;
  logic        next_pwm, next_en;

  // 12500 cycles at 4 ns is 20 kHz, the fastest pwm a host may send
  always_comb begin
    next_pcnt = (pcnt >= 16'(PWM_PER - 1)) ? 16'h0000 : pcnt + 16'h0001;
    next_pwm  = (pcnt < duty);
    next_lcnt = lcnt;
    if (clr_req && lcnt == 16'h0000) begin
      next_lcnt = 16'(CLR_LOW);
    end else if (lcnt != 16'h0000) begin
      next_lcnt = lcnt - 16'h0001;
    end
    // short low pulse of 2.2 us, well inside the clearing window
    next_en = en_cmd && (next_lcnt == 16'h0000);
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pcnt                 <= 16'h0000;
      lcnt                 <= 16'h0000;
      pwm_in               <= 1'b0;
      io_supply_enable_pin <= 1'b0;
    end else begin
      pcnt                 <= next_pcnt;
      lcnt                 <= next_lcnt;
      pwm_in               <= next_pwm;
      io_supply_enable_pin <= next_en;
    end
  end
endmodule

// File: verif/tb_abl_top.sv
`timescale 1ns/1ps
module tb_abl_top;
  typedef struct packed {logic [31:0] exp; logic [31:0] mask;} abl_note_t;
  logic        ref_clk, rst_n, reg_wr, reg_rd, en_cmd, clr_req, probe, rd_d;
  logic        tsg, onset, cutoff, io_supply_enable_pin, pwm_in;
  logic        boost_enable, fault_n, derate_active, led_current_cut;
  logic [7:0]  reg_addr, boost_target, power_fet_gate_drive;
  logic [31:0] reg_wdata, reg_rdata, got;
  logic [3:0]  sysf, sink_below_low, sink_above_mid, sink_above_short, sink_grounded, sink_pwm;
  logic [15:0] duty;
  int          err_count = 0, n_checks = 0, cyc = 0;
  abl_note_t   q[$];
  abl_note_t   nt;
  // packed view of the pins: cut, derate, fault, boost en, gate, code, sinks
  wire  [31:0] obs = {8'h00, led_current_cut, derate_active, fault_n, boost_enable,
                      power_fet_gate_drive, boost_target, sink_pwm};

  // short counts keep recovery and standby entry within the run
  abl_top #(.REC_CYC(200), .CLR_MAX_CYC(600)) u_abl_top (
    .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .io_supply_enable_pin, .pwm_in, .input_overvoltage_fault(sysf[0]),
    .input_undervoltage_lockout(sysf[1]), .input_overcurrent_fault(sysf[2]),
    .die_overtemperature_shutdown(sysf[3]), .thermal_setpoint_grounded(tsg),
    .thermistor_onset(onset), .thermistor_cutoff(cutoff), .sink_below_low,
    .sink_above_mid, .sink_above_short, .sink_grounded, .sink_pwm, .boost_target,
    .boost_enable, .power_fet_gate_drive, .fault_n, .derate_active, .led_current_cut);

  abl_host_model u_abl_host_model (
    .ref_clk, .rst_n, .en_cmd, .clr_req, .duty, .io_supply_enable_pin, .pwm_in);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // pin sample: note first, compared one edge later by the watcher
  task automatic chk(input logic [31:0] e, input logic [31:0] m);
    q.push_back('{e, m});
    probe <= 1'b1;
    @(posedge ref_clk);
    probe <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // gap after the read keeps its compare apart from the next probe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{e, m});
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic wait_pwm(input logic l);
    for (int i = 0; i < 13000 && pwm_in === l; i++) @(posedge ref_clk);
    for (int i = 0; i < 13000 && pwm_in !== l; i++) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
  endtask
  task automatic wait_gate(input logic [7:0] v);
    for (int i = 0; i < 6000 && power_fet_gate_drive !== v; i++) @(posedge ref_clk);
  endtask
  task automatic wait_code(input logic [7:0] v);
    for (int i = 0; i < 6000 && boost_target !== v; i++) @(posedge ref_clk);
  endtask
  // short enable dip; caller has just seen pwm rise: leds dark, device stays active
  task automatic clear_led;
    clr_req <= 1'b1;
    @(posedge ref_clk);
    clr_req <= 1'b0;
    repeat (300) @(posedge ref_clk);
    chk(32'h0, 32'hf);
    repeat (600) @(posedge ref_clk);
    rd(8'h04, 32'h2, 32'hff3);
    chk(32'h0020_0000, 32'h0020_0000);
  endtask

  // ****************************************
  // watcher: oldest note against what shows
  // ****************************************
  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    cyc  <= cyc + 1;
    if (rd_d || probe) begin
      nt  = q.pop_front();
      got = rd_d ? reg_rdata : obs;
      n_checks++;
      if ((got & nt.mask) !== (nt.exp & nt.mask)) begin
        err_count++;
        $display("unexpected at %0t: got %h exp %h", $time, got & nt.mask, nt.exp & nt.mask);
      end
    end
    // pwm waits dominate; worst case stays well below this ceiling
    if (cyc == 100000) begin
      err_count++;
      $display("unexpected at %0t: timeout got %h exp %h", $time, cyc, 0);
      close_out();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {reg_wr, reg_rd, en_cmd, clr_req, probe, tsg, onset, cutoff} = '0;
    {sysf, sink_below_low, sink_above_mid, sink_above_short} = '0;
    reg_addr      = 8'h00;
    reg_wdata     = 32'h0;
    sink_grounded = 4'b1000;
    rst_n         = 1'b0;
    void'($urandom(4));
    duty = 16'd2500 + 16'($urandom % 7500);
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk(32'h0020_0e10, 32'h00ff_ffff);
    rd(8'h00, 32'h0004_00fa, '1);
    wr(8'h08, '1);
    wr(8'h04, '0);
    rd(8'h08, 32'h0, '1);
    rd(8'h04, 32'h00e1_0000, 32'h00ff_0003);
    wr(8'h00, 32'h000f_0010);
    rd(8'h00, 32'h000f_0010, '1);
    // grounded sink reports low headroom; it must be ignored
    sink_below_low <= 4'b1000;
    en_cmd         <= 1'b1;
    wait_gate(8'h01);
    chk(32'h0010_1000, 32'h001f_f000);
    wait_gate(8'he6);
    repeat (20) @(posedge ref_clk);
    rd(8'h04, 32'h2, 32'h3);
    wait_pwm(1'b1);
    chk(32'h7, 32'hf);
    wait_pwm(1'b0);
    chk(32'h0, 32'hf);
    // open string on sink 1
    sink_below_low <= 4'b1010;
    wait_code(8'hff);
    repeat (60) @(posedge ref_clk);
    rd(8'h04, 32'h22, 32'hff3);
    chk(32'h0, 32'h0020_0000);
    wait_pwm(1'b1);
    chk(32'h5, 32'hf);
    sink_below_low <= 4'b1000;
    clear_led();
    // all active sinks high: walk down and stay at the floor
    sink_above_mid <= 4'b0111;
    wait_code(8'h00);
    repeat (100) @(posedge ref_clk);
    chk(32'h0, 32'hff0);
    sink_above_mid <= 4'b0000;
    // a dip shorter than the filter must not move the code
    sink_below_low <= 4'b1100;
    repeat (100) @(posedge ref_clk);
    sink_below_low <= 4'b1000;
    repeat (300) @(posedge ref_clk);
    chk(32'h0, 32'hff0);
    sink_below_low <= 4'b1100;
    for (int i = 0; i < 1500 && boost_target === 8'h00; i++) @(posedge ref_clk);
    chk(32'h10, 32'hff0);
    sink_below_low <= 4'b1000;
    // short on sink 0 while sinks 1 and 2 sit in the window
    sink_above_short <= 4'b0001;
    sink_above_mid   <= 4'b0001;
    repeat (400) @(posedge ref_clk);
    rd(8'h04, 32'h102, 32'hff3);
    wait_pwm(1'b1);
    chk(32'h6, 32'hf);
    sink_above_short <= 4'b0000;
    sink_above_mid   <= 4'b0000;
    clear_led();
    // thermal path
    onset <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(32'h0040_0000, 32'h0040_0000);
    tsg <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(32'h0, 32'h0040_0000);
    tsg    <= 1'b0;
    cutoff <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(32'h0080_0000, 32'h0080_0000);
    // cut must hold while still over the onset point
    cutoff <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk(32'h0080_0000, 32'h0080_0000);
    onset  <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk(32'h0, 32'h0080_0000);
    // each system fault: recovery, then automatic restart
    for (int i = 0; i < 4; i++) begin
      sysf <= 4'(1 << i);
      repeat (10) @(posedge ref_clk);
      chk(32'h0, 32'h003f_f000);
      rd(8'h04, 32'h3, 32'h3);
      sysf <= 4'h0;
      repeat (150) @(posedge ref_clk);
      chk(32'h0, 32'h0020_0000);
      wait_gate(8'he6);
      repeat (20) @(posedge ref_clk);
      chk(32'h003e_6000, 32'h003f_f000);
    end
    // long enable low: standby, fet off, code back to its start value
    en_cmd <= 1'b0;
    repeat (800) @(posedge ref_clk);
    chk(32'h0020_0e10, 32'h003f_ffff);
    rd(8'h04, 32'h0, 32'hff3);
    close_out();
  end
endmodule
